// [logic/rtcmp_pkg.sv]
`default_nettype none
package rtcmp_pkg;
  localparam int EVW = 16;
  localparam int DW = 32;
  localparam int PCW = 16;
  localparam int TBW = 8;
  localparam int TBSW = 3;
  localparam int RDEPTH = 1024;
  localparam int RAW = 10;
  localparam int CNTW = 11;
  localparam logic [CNTW-1:0] FAIL_MAX = 11'h400;
  localparam int DLYW = 4;
  localparam int AUXW = 16;
  localparam int AW = 8;
  localparam int SYNC_RST = 1;
  // ***************************
  // Register byte offsets
  // ***************************
  localparam logic [AW-1:0] A_CMD = 8'h00;
  localparam logic [AW-1:0] A_CFG = 8'h04;
  localparam logic [AW-1:0] A_TRIG_A = 8'h08;
  localparam logic [AW-1:0] A_TRIG_B = 8'h0c;
  localparam logic [AW-1:0] A_PAUSE_EV = 8'h10;
  localparam logic [AW-1:0] A_XREG = 8'h14;
  localparam logic [AW-1:0] A_STOP_CNT = 8'h18;
  localparam logic [AW-1:0] A_STOP_DATA = 8'h1c;
  localparam logic [AW-1:0] A_STOP_STEP = 8'h20;
  localparam logic [AW-1:0] A_AUX_TTL = 8'h24;
  localparam logic [AW-1:0] A_AUX_LVDS = 8'h28;
  localparam logic [AW-1:0] A_FCNT = 8'h2c;
  localparam logic [AW-1:0] A_RES_ADDR = 8'h30;
  localparam logic [AW-1:0] A_RES_DATA = 8'h34;
  localparam logic [AW-1:0] A_RES_INFO = 8'h38;
  // ***************************
  // Command and config fields
  // ***************************
  localparam int CMD_ARM = 0;
  localparam int CMD_TRIG = 1;
  localparam int CMD_PAUSE = 2;
  localparam int CMD_HALT = 3;
  localparam int CFG_CMP_EN = 0;
  localparam int CFG_TWO_LVL = 1;
  localparam int CFG_USE_XREG = 2;
  localparam int CFG_RAW_SEL = 3;
  localparam int CFG_STOP_LSB = 4;
  localparam int CFG_STB_FALL = 6;
  localparam int CFG_TB_TRIG_EN = 7;
  localparam int CFG_TB_PAUSE_EN = 8;
  localparam int CFG_TB_TRIG_LSB = 9;
  localparam int CFG_TB_PAUSE_LSB = 12;
  localparam int CFG_EV_TRIG_EN = 15;
  localparam int CFG_EV_PAUSE_EN = 16;
  localparam int CFG_DLY_LSB = 17;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam int EVM_LSB = 0;
  localparam int EVV_LSB = 16;
  typedef enum logic [1:0] {SM_ERRCNT, SM_RAWCNT, SM_DATA, SM_STEP} rtcmp_stop_e;
  typedef enum logic [1:0] {RS_HALT, RS_PAUSE, RS_RUN} rtcmp_run_e;
endpackage
`default_nettype wire

// [logic/rtcmp_cmp_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface rtcmp_cmp_if;
  import rtcmp_pkg::*;
  logic step;
  logic [PCW-1:0] pc;
  logic [DW-1:0] exp_d;
  logic [DW-1:0] mask;
  logic [DW-1:0] rx;
  logic raw_sel;
  logic [DLYW-1:0] dly;
  logic res_valid;
  logic [DW-1:0] res_data;
  logic [DW-1:0] res_raw;
  logic [PCW-1:0] res_pc;
  logic res_status;
  modport ctl (output step, pc, exp_d, mask, rx, raw_sel, dly,
    input res_valid, res_data, res_raw, res_pc, res_status);
  modport eng (input step, pc, exp_d, mask, rx, raw_sel, dly,
    output res_valid, res_data, res_raw, res_pc, res_status);
endinterface
`default_nettype wire

// [logic/rtcmp_engine.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcmp_engine #(
  parameter int DLY_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  rtcmp_cmp_if.eng cif
);
  import rtcmp_pkg::*;
  logic [DW-1:0] exp_pipe [DLY_DEPTH];
  logic [DW-1:0] mask_pipe [DLY_DEPTH];
  logic [DW-1:0] exp_sel;
  logic [DW-1:0] mask_sel;
  logic [DW-1:0] fail;
  // ***************************
  // Expected and mask delay line
  // ***************************
  // programmable path delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        exp_pipe[i] <= '0;
        mask_pipe[i] <= '0;
      end
    end else if (cif.step) begin
      exp_pipe[0] <= cif.exp_d;
      mask_pipe[0] <= cif.mask;
      for (int i = 1; i < DLY_DEPTH; i++) begin
        exp_pipe[i] <= exp_pipe[i-1];
        mask_pipe[i] <= mask_pipe[i-1];
      end
    end
  end
  assign exp_sel = (cif.dly == '0) ? cif.exp_d : exp_pipe[cif.dly - 1'b1];
  assign mask_sel = (cif.dly == '0) ? cif.mask : mask_pipe[cif.dly - 1'b1];
  assign fail = (cif.rx ^ exp_sel) & mask_sel;
  // ***************************
  // Result word
  // ***************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cif.res_valid <= 1'b0;
      cif.res_data <= '0;
      cif.res_raw <= '0;
      cif.res_pc <= '0;
      cif.res_status <= 1'b0;
    end else begin
      cif.res_valid <= cif.step;
      if (cif.step) begin
        cif.res_data <= cif.raw_sel ? cif.rx : fail;
        cif.res_raw <= cif.rx;
        cif.res_pc <= cif.pc;
        cif.res_status <= |fail;
      end
    end
  end
  // ***************************
  // Checks
  // ***************************
  property p_mask_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    cif.step && cif.dly == '0 && cif.mask == '0 |=> cif.res_valid && !cif.res_status;
  endproperty
  a_mask_zero: assert property (p_mask_zero)
    else $error("masked step reported a failure");
  property p_fail_seen;
    @(posedge clk_i) disable iff (!rst_n_i)
    cif.step && cif.dly == '0 && ((cif.rx ^ cif.exp_d) & cif.mask) != '0
      |=> cif.res_status;
  endproperty
  a_fail_seen: assert property (p_fail_seen)
    else $error("unmasked mismatch not flagged");
endmodule
`default_nettype wire

// [logic/rtcmp_top.sv]
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module rtcmp_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [rtcmp_pkg::AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ext_trig_n_i,
  input wire logic ext_pause_n_i,
  input wire logic [rtcmp_pkg::EVW-1:0] ext_evt_i,
  input wire logic [rtcmp_pkg::TBW-1:0] tbus_n_i,
  input wire logic stop_sync_n_i,
  output logic stop_n_o,
  input wire logic strobe_i,
  input wire logic [rtcmp_pkg::DW-1:0] chan_i,
  output logic [rtcmp_pkg::DW-1:0] chan_o,
  output logic [rtcmp_pkg::DW-1:0] chan_oe_n_o,
  input wire logic step_i,
  input wire logic [rtcmp_pkg::PCW-1:0] pc_i,
  input wire logic [rtcmp_pkg::DW-1:0] exp_i,
  input wire logic [rtcmp_pkg::DW-1:0] mask_i,
  input wire logic [rtcmp_pkg::DW-1:0] dir_i,
  input wire logic seq_end_i,
  output logic run_o,
  output logic pause_o,
  output logic aux_ttl_clock_o,
  output logic aux_lvds_clock_o
);
  import rtcmp_pkg::*;
  localparam int SW = EVW + TBW + DW + 4;
  // ***************************
  // Pin synchronisers
  // ***************************
  logic [SW-1:0] pin_raw, s1_q, s2_q, s3_q, flt_q;
  logic [EVW-1:0] ev_pin;
  logic [TBW-1:0] tb_n;
  logic [DW-1:0] chan_f;
  logic stb_f, stb_p_q, dstop_n, xpause_n, xtrig_n;
  assign pin_raw = {ext_evt_i, tbus_n_i, chan_i, strobe_i, stop_sync_n_i,
    ext_pause_n_i, ext_trig_n_i};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      flt_q <= '1;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
    end
  end
  assign ev_pin = flt_q[SW-1 -: EVW];
  assign tb_n = flt_q[DW+4 +: TBW];
  assign chan_f = flt_q[4 +: DW];
  assign stb_f = flt_q[3];
  assign dstop_n = flt_q[2];
  assign xpause_n = flt_q[1];
  assign xtrig_n = flt_q[0];
  // ***************************
  // Register file
  // ***************************
  logic [31:0] cfg_q, trig_a_q, trig_b_q, pause_ev_q, stop_data_q;
  logic [EVW-1:0] xreg_q;
  logic [CNTW-1:0] stop_cnt_q;
  logic [PCW-1:0] stop_step_q;
  logic [RAW-1:0] res_raddr_q;
  logic [AUXW-1:0] aux_div_q [2];
  logic wr_cmd, sw_arm, sw_trig, sw_pause, sw_halt;
  assign wr_cmd = wr_i && addr_i == A_CMD;
  assign sw_arm = wr_cmd && wdata_i[CMD_ARM];
  assign sw_trig = wr_cmd && wdata_i[CMD_TRIG];
  assign sw_pause = wr_cmd && wdata_i[CMD_PAUSE];
  assign sw_halt = wr_cmd && wdata_i[CMD_HALT];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= CFG_RST;
      trig_a_q <= '0;
      trig_b_q <= '0;
      pause_ev_q <= '0;
      xreg_q <= '0;
      stop_cnt_q <= '0;
      stop_data_q <= '0;
      stop_step_q <= '0;
      res_raddr_q <= '0;
    end else if (wr_i) begin
      unique case (addr_i)
        A_CFG: cfg_q <= wdata_i;
        A_TRIG_A: trig_a_q <= wdata_i;
        A_TRIG_B: trig_b_q <= wdata_i;
        A_PAUSE_EV: pause_ev_q <= wdata_i;
        A_XREG: xreg_q <= wdata_i[EVW-1:0];
        A_STOP_CNT: stop_cnt_q <= wdata_i[CNTW-1:0];
        A_STOP_DATA: stop_data_q <= wdata_i;
        A_STOP_STEP: stop_step_q <= wdata_i[PCW-1:0];
        A_RES_ADDR: res_raddr_q <= wdata_i[RAW-1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (wr_i && addr_i == A_AUX_TTL) begin
      aux_div_q[0] <= wdata_i[AUXW-1:0];
    end
    if (wr_i && addr_i == A_AUX_LVDS) begin
      aux_div_q[1] <= wdata_i[AUXW-1:0];
    end
  end
  // ***************************
  // Auxiliary clock dividers
  // ***************************
  logic [1:0] aux_clk_q;
  for (genvar g = 0; g < 2; g++) begin : g_aux
    logic [AUXW-1:0] cnt_q;
    logic clk_q;
    assign aux_clk_q[g] = clk_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_q <= '0;
        clk_q <= 1'b0;
      end else if (cnt_q >= aux_div_q[g]) begin
        cnt_q <= '0;
        clk_q <= ~clk_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  assign aux_ttl_clock_o = aux_clk_q[0];
  assign aux_lvds_clock_o = aux_clk_q[1];
  // ***************************
  // Trigger and pause conditions
  // ***************************
  function automatic logic ev_hit(input logic [EVW-1:0] ev, input logic [31:0] r);
    return (ev & r[EVM_LSB +: EVW]) == r[EVV_LSB +: EVW];
  endfunction
  rtcmp_run_e state_q;
  logic [EVW-1:0] ev_src;
  logic hit_a, hit_b, hit_p, trig_evt, tb_trig, tb_pause;
  logic trig_any, pause_any, stop_req, own_stop_q;
  logic [1:0] lvl_q;
  assign ev_src = cfg_q[CFG_USE_XREG] ? xreg_q : ev_pin;
  assign hit_a = ev_hit(ev_src, trig_a_q);
  assign hit_b = ev_hit(ev_src, trig_b_q);
  assign hit_p = ev_hit(ev_src, pause_ev_q);
  assign trig_evt = cfg_q[CFG_TWO_LVL] ? ((lvl_q[0] && hit_b) || (lvl_q[1] && hit_a))
    : (hit_a || hit_b);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_q <= '0;
    end else if (state_q != RS_PAUSE) begin
      lvl_q <= '0;
    end else if (lvl_q == '0) begin
      lvl_q <= {hit_b, hit_a && !hit_b};
    end
  end
  assign tb_trig = cfg_q[CFG_TB_TRIG_EN] && !tb_n[cfg_q[CFG_TB_TRIG_LSB +: TBSW]];
  assign tb_pause = cfg_q[CFG_TB_PAUSE_EN] && !tb_n[cfg_q[CFG_TB_PAUSE_LSB +: TBSW]];
  assign trig_any = !xtrig_n || sw_trig || tb_trig
    || (cfg_q[CFG_EV_TRIG_EN] && trig_evt);
  assign pause_any = sw_pause || !xpause_n || tb_pause
    || (cfg_q[CFG_EV_PAUSE_EN] && hit_p);
  assign stop_req = own_stop_q || !dstop_n || seq_end_i;
  // ***************************
  // Run control
  // ***************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= RS_HALT;
    end else if (sw_halt) begin
      state_q <= RS_HALT;
    end else begin
      unique case (state_q)
        RS_HALT: begin
          if (sw_arm) begin
            state_q <= RS_PAUSE;
          end
        end
        RS_PAUSE: begin
          if (!pause_any && trig_any) begin
            state_q <= RS_RUN;
          end
        end
        RS_RUN: begin
          if (stop_req) begin
            state_q <= RS_HALT;
          end else if (pause_any) begin
            state_q <= RS_PAUSE;
          end
        end
      endcase
    end
  end
  assign run_o = state_q == RS_RUN;
  assign pause_o = state_q == RS_PAUSE;
  // ***************************
  // Channel drive and capture
  // ***************************
  rtcmp_cmp_if cif ();
  logic [DW-1:0] rx_q;
  logic stb_edge;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_o <= '0;
      chan_oe_n_o <= '1;
    end else if (state_q == RS_HALT) begin
      chan_oe_n_o <= '1;
    end else if (step_i) begin
      chan_o <= exp_i;
      chan_oe_n_o <= ~dir_i;
    end
  end
  assign stb_edge = cfg_q[CFG_STB_FALL] ? (stb_p_q && !stb_f) : (!stb_p_q && stb_f);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stb_p_q <= 1'b1;
      rx_q <= '0;
    end else begin
      stb_p_q <= stb_f;
      if (stb_edge) begin
        rx_q <= chan_f;
      end
    end
  end
  // expected and mask inputs feed engine
  assign cif.step = step_i && cfg_q[CFG_CMP_EN] && state_q == RS_RUN;
  assign cif.pc = pc_i;
  assign cif.exp_d = exp_i;
  assign cif.mask = mask_i;
  assign cif.rx = rx_q;
  assign cif.raw_sel = cfg_q[CFG_RAW_SEL];
  assign cif.dly = cfg_q[CFG_DLY_LSB +: DLYW];
  rtcmp_engine #(
    .DLY_DEPTH(16)
  ) u_engine (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cif(cif.eng)
  );
  // ***************************
  // Result memory and stop modes
  // ***************************
  localparam int EW = 1 + PCW + DW;
  logic [EW-1:0] res_mem [RDEPTH];
  logic [RAW-1:0] wr_ptr_q;
  logic [RAW:0] fill_q, post_q;
  logic [CNTW-1:0] fail_cnt_q, fail_cnt_d;
  logic trig_seen_q, res_wr, cnt_hit, fifo_hit;
  rtcmp_stop_e mode;
  assign mode = rtcmp_stop_e'(cfg_q[CFG_STOP_LSB +: 2]);
  assign res_wr = cif.res_valid && !own_stop_q && state_q != RS_HALT
    && (mode != SM_ERRCNT || fill_q != RDEPTH[RAW:0]);
  assign fail_cnt_d = (cif.res_status && fail_cnt_q != FAIL_MAX) ? fail_cnt_q + 1'b1
    : fail_cnt_q;
  assign cnt_hit = stop_cnt_q != '0 && fail_cnt_d == stop_cnt_q;
  always_comb begin
    unique case (mode)
      SM_RAWCNT: fifo_hit = cnt_hit;
      SM_DATA: fifo_hit = cif.res_raw == stop_data_q;
      SM_STEP: fifo_hit = cif.res_pc == stop_step_q;
      SM_ERRCNT: fifo_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (res_wr) begin
      res_mem[wr_ptr_q] <= {cif.res_status, cif.res_pc, cif.res_data};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      fill_q <= '0;
      post_q <= '0;
      fail_cnt_q <= '0;
      trig_seen_q <= 1'b0;
      own_stop_q <= 1'b0;
    end else if (sw_arm) begin
      wr_ptr_q <= '0;
      fill_q <= '0;
      post_q <= '0;
      fail_cnt_q <= '0;
      trig_seen_q <= 1'b0;
      own_stop_q <= 1'b0;
    end else if (cif.res_valid && !own_stop_q && state_q != RS_HALT) begin
      fail_cnt_q <= fail_cnt_d;
      if (res_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
        if (fill_q != RDEPTH[RAW:0]) begin
          fill_q <= fill_q + 1'b1;
        end
      end
      if (mode == SM_ERRCNT) begin
        own_stop_q <= cnt_hit;
      end else if (trig_seen_q) begin
        post_q <= post_q - 1'b1;
        own_stop_q <= post_q == (RAW + 1)'(1);
      end else if (fifo_hit) begin
        trig_seen_q <= 1'b1;
        post_q <= (RAW + 1)'(RDEPTH - 1);
      end
    end
  end
  assign stop_n_o = !own_stop_q;
  // ***************************
  // Register read
  // ***************************
  logic [EW-1:0] rd_ent;
  logic [31:0] rd_mux;
  assign rd_ent = res_mem[res_raddr_q];
  always_comb begin
    rd_mux = '0;
    unique case (addr_i)
      A_CMD: rd_mux = {27'h0, trig_seen_q, own_stop_q, 1'b0, state_q};
      A_CFG: rd_mux = cfg_q;
      A_TRIG_A: rd_mux = trig_a_q;
      A_TRIG_B: rd_mux = trig_b_q;
      A_PAUSE_EV: rd_mux = pause_ev_q;
      A_XREG: rd_mux = {16'h0, xreg_q};
      A_STOP_CNT: rd_mux = {21'h0, stop_cnt_q};
      A_STOP_DATA: rd_mux = stop_data_q;
      A_STOP_STEP: rd_mux = {16'h0, stop_step_q};
      A_FCNT: rd_mux = {5'h0, fill_q, 5'h0, fail_cnt_q};
      A_RES_ADDR: rd_mux = {22'h0, res_raddr_q};
      A_RES_DATA: rd_mux = rd_ent[DW-1:0];
      A_RES_INFO: rd_mux = {15'h0, rd_ent[EW-1:DW]};
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end
  // ***************************
  // Checks
  // ***************************
  property p_xtrig;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == RS_PAUSE && !xtrig_n && !pause_any && !sw_halt |=> state_q == RS_RUN;
  endproperty
  a_xtrig: assert property (p_xtrig)
    else $error("external trigger did not start run");
  property p_sw_pause;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == RS_RUN && sw_pause && !sw_halt && !stop_req |=> state_q == RS_PAUSE;
  endproperty
  a_sw_pause: assert property (p_sw_pause)
    else $error("software pause ignored");
  property p_xpause;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == RS_PAUSE && !xpause_n && !sw_halt |=> state_q == RS_PAUSE;
  endproperty
  a_xpause: assert property (p_xpause)
    else $error("external pause overridden");
  property p_ev_pause;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == RS_RUN && cfg_q[CFG_EV_PAUSE_EN] && hit_p && !stop_req && !sw_halt
      |=> state_q == RS_PAUSE;
  endproperty
  a_ev_pause: assert property (p_ev_pause)
    else $error("event pause missed");
  property p_tb_trig;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == RS_PAUSE && tb_trig && !pause_any && !sw_halt |=> run_o;
  endproperty
  a_tb_trig: assert property (p_tb_trig)
    else $error("test-bus trigger missed");
  property p_cnt_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
    mode == SM_ERRCNT && cif.res_valid && state_q == RS_RUN && !own_stop_q
      && cnt_hit && !sw_arm && !sw_halt |=> own_stop_q && !stop_n_o ##1 state_q == RS_HALT;
  endproperty
  a_cnt_stop: assert property (p_cnt_stop)
    else $error("count stop not taken");
  property p_fifo_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(own_stop_q) && mode != SM_ERRCNT |-> $past(trig_seen_q);
  endproperty
  a_fifo_stop: assert property (p_fifo_stop)
    else $error("fifo stop without trigger");
  property p_fcnt;
    @(posedge clk_i) disable iff (!rst_n_i)
    cif.res_valid && cif.res_status && state_q != RS_HALT && !own_stop_q && !sw_arm
      && fail_cnt_q != FAIL_MAX |=> fail_cnt_q == $past(fail_cnt_q) + 1'b1;
  endproperty
  a_fcnt: assert property (p_fcnt)
    else $error("failure count not advanced");
  property p_dstop;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_q == RS_RUN && !dstop_n |=> state_q == RS_HALT;
  endproperty
  a_dstop: assert property (p_dstop)
    else $error("domain stop ignored");
  c_run: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == RS_PAUSE ##1 state_q == RS_RUN);
  c_two_lvl: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_q[CFG_TWO_LVL] && state_q == RS_PAUSE && trig_evt);
  c_own_stop: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(own_stop_q));
endmodule
`default_nettype wire

// [test/rtcmp_uut_model.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcmp_uut_model (
  input wire logic clk_i,
  output logic strobe_o,
  output logic [31:0] chan_o,
  output logic step_o,
  output logic [15:0] pc_o,
  output logic [31:0] exp_o,
  output logic [31:0] mask_o,
  output logic [31:0] dir_o
);
  initial begin
    {strobe_o, step_o, pc_o, exp_o, mask_o, dir_o} = '0;
    chan_o = '1;
  end
  // ***
  // Unit answers, strobe latches, step
  // ***
  task automatic do_step(input logic [15:0] p, input logic [31:0] e, m, d, rx);
    @(posedge clk_i);
    chan_o <= rx;
    repeat (2) @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    strobe_o <= 1'b0;
    {step_o, pc_o, exp_o, mask_o, dir_o} <= {1'b1, p, e, m, d};
    @(posedge clk_i);
    step_o <= 1'b0;
    chan_o <= ~rx;
  endtask
endmodule
`default_nettype wire

// [test/trigger_pause_realtime_compare_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module trigger_pause_realtime_compare_tb_top;
  import rtcmp_pkg::*;
  logic clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, trig_n = 1, pause_n = 1;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata, cho, oe_n, chi, ex, mk, dr, d;
  logic strobe, step, run, pause, stop_n;
  logic aux_t, aux_l, dstop_n = 1;
  logic [7:0] tbus = 8'hff;
  logic [15:0] pc;
  int n_mismatch = 0, check_count = 0;
  always #2 clk_i = ~clk_i;
  rtcmp_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_trig_n_i(trig_n),
    .ext_pause_n_i(pause_n), .ext_evt_i(16'h0000), .tbus_n_i(tbus),
    .stop_sync_n_i(dstop_n), .stop_n_o(stop_n), .strobe_i(strobe), .chan_i(chi),
    .chan_o(cho), .chan_oe_n_o(oe_n), .step_i(step), .pc_i(pc), .exp_i(ex),
    .mask_i(mk), .dir_i(dr), .seq_end_i(1'b0), .run_o(run), .pause_o(pause),
    .aux_ttl_clock_o(aux_t), .aux_lvds_clock_o(aux_l));
  rtcmp_uut_model uut (.clk_i(clk_i), .strobe_o(strobe), .chan_o(chi),
    .step_o(step), .pc_o(pc), .exp_o(ex), .mask_o(mk), .dir_o(dr));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic state_is(input logic [1:0] s);
    repeat (8) @(posedge clk_i);
    #1 chk({30'h0, run, pause}, {30'h0, s});
  endtask
  // ***
  // Scenarios
  // ***
  task automatic t_sw;
    wreg(A_CMD, 32'h0000_0001);
    state_is(2'b01);
    wreg(A_CMD, 32'h0000_0002);
    state_is(2'b10);
    wreg(A_CMD, 32'h0000_0004);
    state_is(2'b01);
    $display("software run control done");
  endtask
  task automatic t_pins;
    @(posedge clk_i);
    pause_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wreg(A_CMD, 32'h0000_0002);
    state_is(2'b01);
    @(posedge clk_i);
    pause_n <= 1'b1;
    trig_n <= 1'b0;
    state_is(2'b10);
    @(posedge clk_i);
    trig_n <= 1'b1;
    wreg(A_CMD, 32'h0000_0008);
    state_is(2'b00);
    $display("pin run control done");
  endtask
  task automatic t_cmp;
    wreg(A_CMD, 32'h0000_0001);
    wreg(A_CFG, 32'h0000_0001);
    wreg(A_CMD, 32'h0000_0002);
    state_is(2'b10);
    uut.do_step(16'h0005, 32'h1234_0000, 32'h0000_00ff, 32'hffff_0000, 32'h0000_00f0);
    wreg(A_CFG, 32'h0000_0009);
    uut.do_step(16'h0006, 32'h0000_0000, 32'h0000_0000, 32'hffff_0000, 32'h0000_000f);
    #1 chk(cho, 32'h0000_0000);
    chk(oe_n, 32'h0000_ffff);
    wreg(A_RES_ADDR, 32'h0000_0000);
    rreg(A_RES_DATA, d);
    chk(d, 32'h0000_00f0);
    rreg(A_RES_INFO, d);
    chk(d, 32'h0001_0005);
    wreg(A_RES_ADDR, 32'h0000_0001);
    rreg(A_RES_DATA, d);
    chk(d, 32'h0000_000f);
    rreg(A_RES_INFO, d);
    chk(d, 32'h0000_0006);
    rreg(A_FCNT, d);
    chk(d, 32'h0002_0001);
    wreg(A_STOP_CNT, 32'h0000_0002);
    uut.do_step(16'h0007, 32'h0000_0000, 32'h0000_00ff, 32'h0000_0000, 32'h0000_0001);
    state_is(2'b00);
    chk({31'h0, stop_n}, 32'h0000_0000);
    $display("compare done");
  endtask
  task automatic t_ev;
    wreg(A_TRIG_A, 32'h0012_00ff);
    wreg(A_TRIG_B, 32'h3400_ff00);
    wreg(A_PAUSE_EV, 32'h5555_ffff);
    wreg(A_CFG, 32'h0001_8006);
    wreg(A_CMD, 32'h0000_0001);
    wreg(A_XREG, 32'h0000_0012);
    state_is(2'b01);
    wreg(A_XREG, 32'h0000_3400);
    state_is(2'b10);
    wreg(A_XREG, 32'h0000_5555);
    state_is(2'b01);
    rreg(A_XREG, d);
    chk(d, 32'h0000_5555);
    wreg(A_CMD, 32'h0000_0008);
    $display("event run control done");
  endtask
  task automatic t_tb;
    wreg(A_CFG, 32'h0000_5780);
    wreg(A_CMD, 32'h0000_0001);
    state_is(2'b01);
    @(posedge clk_i);
    tbus <= 8'hf7;
    state_is(2'b10);
    @(posedge clk_i);
    tbus <= 8'hd7;
    state_is(2'b01);
    @(posedge clk_i);
    tbus <= 8'hf7;
    state_is(2'b10);
    @(posedge clk_i);
    dstop_n <= 1'b0;
    state_is(2'b00);
    @(posedge clk_i);
    dstop_n <= 1'b1;
    tbus <= 8'hff;
    state_is(2'b00);
    $display("test-bus and domain stop done");
  endtask
  task automatic t_fifo;
    wreg(A_CFG, 32'h0000_0031);
    wreg(A_STOP_STEP, 32'h0000_0003);
    wreg(A_CMD, 32'h0000_0001);
    wreg(A_CMD, 32'h0000_0002);
    state_is(2'b10);
    for (int i = 0; i < 1026; i++) begin
      uut.do_step(16'(i), '0, '0, '0, '0);
    end
    state_is(2'b10);
    uut.do_step(16'h0402, '0, '0, '0, '0);
    state_is(2'b00);
    rreg(A_FCNT, d);
    chk(d, 32'h0400_0000);
    wreg(A_RES_ADDR, 32'h0000_0003);
    rreg(A_RES_INFO, d);
    chk(d, 32'h0000_0003);
    wreg(A_RES_ADDR, 32'h0000_0002);
    rreg(A_RES_INFO, d);
    chk(d, 32'h0000_0402);
    $display("step-match fifo stop done");
  endtask
  task automatic t_aux;
    int nt = 0;
    int nl = 0;
    logic pt, pl;
    wreg(A_AUX_TTL, 32'h0000_0001);
    wreg(A_AUX_LVDS, 32'h0000_0002);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    pt = 1'b0;
    pl = 1'b0;
    repeat (12) begin
      @(posedge clk_i);
      #1;
      nt += (aux_t !== pt);
      nl += (aux_l !== pl);
      pt = aux_t;
      pl = aux_l;
    end
    chk(nt, 32'd6);
    chk(nl, 32'd4);
    chk({31'h0, stop_n}, 32'h0000_0001);
    $display("aux clock and reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_sw();
    t_pins();
    t_ev();
    t_tb();
    t_cmp();
    t_fifo();
    t_aux();
    report_and_stop();
  end
  initial begin
    #80000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
